/* hw/ssf_top.sv */
// Supply status flags: serial management slave and status register
`timescale 1ns/1ps
`default_nettype none
module ssf_top
  import ssf_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR       = SSF_DEV_ADDR_DFLT, // Arbitrary address value
  parameter int         REFRESH_CYCLES = SSF_REFRESH_CYC,
  parameter int         NUM_OUTPUTS    = SSF_NUM_OUTPUTS
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic                   temp_warn_cmp,
  input  wire logic                   input_above_uv_cmp,
  input  wire logic                   main_supply_sense_pin,
  input  wire logic [NUM_OUTPUTS-1:0] output_power_good_cmp,
  input  wire logic [NUM_OUTPUTS-1:0] first_route_sel,
  input  wire logic [NUM_OUTPUTS-1:0] second_route_sel,
  output logic                        first_routed_good_pin,
  output logic                        second_routed_good_pin
);
  ssf_status_if st ();

  ssf_status_core #(
    .REFRESH_CYCLES (REFRESH_CYCLES),
    .NUM_OUTPUTS    (NUM_OUTPUTS)
  ) u_core (
    .sys_clk                (sys_clk),
    .nrst                   (nrst),
    .temp_warn_cmp          (temp_warn_cmp),
    .input_above_uv_cmp     (input_above_uv_cmp),
    .main_supply_sense_pin  (main_supply_sense_pin),
    .output_power_good_cmp  (output_power_good_cmp),
    .first_route_sel        (first_route_sel),
    .second_route_sel       (second_route_sel),
    .first_routed_good_pin  (first_routed_good_pin),
    .second_routed_good_pin (second_routed_good_pin),
    .st                     (st)
  );

  logic [1:0]  scl_sync_ff;
  logic [1:0]  sda_sync_ff;
  logic        scl_prev_ff;
  logic        sda_prev_ff;
  ssf_state_t  state_ff;
  ssf_state_t  nxt_state;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic [7:0]  shift_ff;
  logic [7:0]  tx_ff;
  logic [7:0]  nxt_tx;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic        rw_ff;
  logic        nxt_rw;
  logic        nack_ff;
  logic        oe_ff;
  logic        nxt_oe;
  logic        clear_ff;
  logic        nxt_clear;

  wire scl      = scl_sync_ff[1];
  wire sda      = sda_sync_ff[1];
  wire scl_rise = scl & ~scl_prev_ff;
  wire scl_fall = ~scl & scl_prev_ff;
  wire start    = scl & scl_prev_ff & sda_prev_ff & ~sda;
  wire stop     = scl & scl_prev_ff & ~sda_prev_ff & sda;
  wire byte_done = (cnt_ff == SSF_BITS_PER_BYTE);
  wire addr_hit  = (shift_ff[7:1] == DEV_ADDR);
  wire ptr_hit   = (ptr_ff == SSF_STATUS_OFFSET);
  // Snapshot taken once per byte so live comparators cannot tear it
  wire [7:0] read_byte = ptr_hit ? st.live_status : SSF_UNMAPPED_READ;
  wire shifting  = (state_ff == SSF_ADDR) || (state_ff == SSF_PTR) || (state_ff == SSF_WDATA)
                   || (state_ff == SSF_RDATA);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_tx    = tx_ff;
    nxt_ptr   = ptr_ff;
    nxt_rw    = rw_ff;
    nxt_oe    = oe_ff;
    nxt_clear = 1'b0;
    if (start)
    begin
      nxt_state = SSF_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
    end
    else if (stop)
    begin
      nxt_state = SSF_IDLE;
      nxt_oe    = 1'b0;
    end
    else if (scl_rise && shifting)
      nxt_cnt = cnt_ff + 4'h1;
    else if (scl_fall)
    begin
      unique case (state_ff)
        SSF_IDLE: ;
        SSF_ADDR:
          if (byte_done)
          begin
            nxt_state = addr_hit ? SSF_ADDR_ACK : SSF_IDLE;
            nxt_oe    = addr_hit;
            nxt_rw    = shift_ff[0];
          end
        SSF_ADDR_ACK:
        begin
          nxt_cnt = 4'h0;
          if (rw_ff)
          begin
            nxt_state = SSF_RDATA;
            nxt_tx    = {read_byte[6:0], 1'b0};
            nxt_oe    = ~read_byte[7];
          end
          else
          begin
            nxt_state = SSF_PTR;
            nxt_oe    = 1'b0;
          end
        end
        SSF_PTR:
          if (byte_done)
          begin
            nxt_state = SSF_PTR_ACK;
            nxt_ptr   = shift_ff;
            nxt_oe    = 1'b1;
          end
        SSF_PTR_ACK, SSF_WDATA_ACK:
        begin
          nxt_state = SSF_WDATA;
          nxt_cnt   = 4'h0;
          nxt_oe    = 1'b0;
        end
        SSF_WDATA:
          if (byte_done)
          begin
            nxt_state = SSF_WDATA_ACK;
            nxt_oe    = 1'b1;
            nxt_ptr   = ptr_ff + 8'h01;
            // Only bit 6 written as 1 has any effect
            nxt_clear = ptr_hit & shift_ff[SSF_BIT_INPUT_UNDERVOLTAGE_FLAG];
          end
        SSF_RDATA:
          if (byte_done)
          begin
            nxt_state = SSF_RDATA_ACK;
            nxt_oe    = 1'b0;
          end
          else
          begin
            nxt_oe = ~tx_ff[7];
            nxt_tx = {tx_ff[6:0], 1'b0};
          end
        SSF_RDATA_ACK:
          if (nack_ff)
            nxt_state = SSF_IDLE;
          else
          begin
            nxt_state = SSF_RDATA;
            nxt_cnt   = 4'h0;
            nxt_ptr   = ptr_ff + 8'h01;
            nxt_tx    = (ptr_ff + 8'h01 == SSF_STATUS_OFFSET) ?
                        {st.live_status[6:0], 1'b0} : {SSF_UNMAPPED_READ[6:0], 1'b0};
            nxt_oe    = (ptr_ff + 8'h01 == SSF_STATUS_OFFSET) ?
                        ~st.live_status[7] : ~SSF_UNMAPPED_READ[7];
          end
        default:
        begin
          nxt_state = SSF_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl;
      sda_prev_ff <= sda;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= SSF_IDLE;
      cnt_ff   <= 4'h0;
      tx_ff    <= 8'h00;
      ptr_ff   <= 8'h00;
      rw_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      clear_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      tx_ff    <= nxt_tx;
      ptr_ff   <= nxt_ptr;
      rw_ff    <= nxt_rw;
      oe_ff    <= nxt_oe;
      clear_ff <= nxt_clear;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_ff <= 8'h00;
      nack_ff  <= 1'b0;
    end
    else if (scl_rise)
    begin
      shift_ff <= {shift_ff[6:0], sda};
      if (state_ff == SSF_RDATA_ACK)
        nack_ff <= sda;
    end
  end

  assign st.uv_clear = clear_ff;
  assign sda_oe      = oe_ff;
  // Open drain: only ever pulls low
  assign sda_out     = 1'b0;
endmodule // ssf_top
`default_nettype wire

/* hw/ssf_pkg.sv */
// Constants shared by the supply status flag block
package ssf_pkg;
  localparam logic [7:0] SSF_STATUS_OFFSET = 8'h1A;
  localparam int         SSF_BIT_TEMP_WARN = 7;
  localparam int         SSF_BIT_INPUT_UNDERVOLTAGE_FLAG   = 6;
  localparam int         SSF_BIT_SENSE     = 5;
  localparam int         SSF_NUM_OUTPUTS   = 5;
  localparam logic       SSF_INPUT_UNDERVOLTAGE_FLAG_RST   = 1'b0;
  localparam logic [7:0] SSF_UNMAPPED_READ = 8'h00;
  localparam logic [6:0] SSF_DEV_ADDR_DFLT = 7'h2C;
  localparam int         SSF_CLK_HZ        = 40000000;
  localparam int         SSF_REFRESH_US    = 250;
  localparam int         SSF_REFRESH_CYC   = (SSF_CLK_HZ / 1000000) * SSF_REFRESH_US;
  localparam logic [3:0] SSF_BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    SSF_IDLE      = 4'b0000,
    SSF_ADDR      = 4'b0001,
    SSF_ADDR_ACK  = 4'b0010,
    SSF_PTR       = 4'b0011,
    SSF_PTR_ACK   = 4'b0100,
    SSF_WDATA     = 4'b0101,
    SSF_WDATA_ACK = 4'b0110,
    SSF_RDATA     = 4'b0111,
    SSF_RDATA_ACK = 4'b1000
  } ssf_state_t;
endpackage

/* hw/ssf_status_if.sv */
// Status byte and flag clear between serial port and status core
`timescale 1ns/1ps
`default_nettype none
interface ssf_status_if;
  logic [7:0] live_status;
  logic       uv_clear;
  modport core (output live_status, input uv_clear);
  modport port (input live_status, output uv_clear);
endinterface // ssf_status_if
`default_nettype wire

/* hw/ssf_status_core.sv */
// Comparator synchronisers, sticky undervoltage flag and routed good pins
`timescale 1ns/1ps
`default_nettype none
module ssf_status_core
  import ssf_pkg::*;
#(
  parameter int REFRESH_CYCLES = SSF_REFRESH_CYC,
  parameter int NUM_OUTPUTS    = SSF_NUM_OUTPUTS
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   temp_warn_cmp,
  input  wire logic                   input_above_uv_cmp,
  input  wire logic                   main_supply_sense_pin,
  input  wire logic [NUM_OUTPUTS-1:0] output_power_good_cmp,
  input  wire logic [NUM_OUTPUTS-1:0] first_route_sel,
  input  wire logic [NUM_OUTPUTS-1:0] second_route_sel,
  output logic                        first_routed_good_pin,
  output logic                        second_routed_good_pin,
  ssf_status_if.core                  st
);
  localparam int SW = NUM_OUTPUTS + 3;
  localparam int CW = $clog2(REFRESH_CYCLES);
  localparam logic [CW-1:0] TICK_LAST = CW'(REFRESH_CYCLES - 1);

  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic          prev_above_ff;
  logic          armed_ff;
  logic          input_undervoltage_flag_ff;
  logic          refresh_pend_ff;
  logic [CW-1:0] tick_cnt_ff;
  logic          first_good_ff;
  logic          second_good_ff;

  wire [SW-1:0]          raw_in = {temp_warn_cmp, input_above_uv_cmp, main_supply_sense_pin,
                                   output_power_good_cmp};
  wire                   above  = sync2_ff[NUM_OUTPUTS+1];
  wire [NUM_OUTPUTS-1:0] pg     = sync2_ff[NUM_OUTPUTS-1:0];
  wire                   tick   = (tick_cnt_ff == TICK_LAST);
  wire                   uv_fall = armed_ff & prev_above_ff & ~above;
  wire                   uv_refresh = refresh_pend_ff & tick & armed_ff & ~above;
  // Set terms win over a clear arriving in the same cycle
  wire                   nxt_input_undervoltage_flag = uv_fall | uv_refresh | (input_undervoltage_flag_ff & ~st.uv_clear);
  wire                   nxt_first_good  = &(pg | ~first_route_sel);
  wire                   nxt_second_good = &(pg | ~second_route_sel);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_above_ff   <= 1'b0;
      armed_ff        <= 1'b0;
      input_undervoltage_flag_ff      <= SSF_INPUT_UNDERVOLTAGE_FLAG_RST;
      refresh_pend_ff <= 1'b0;
      tick_cnt_ff     <= '0;
    end
    else
    begin
      prev_above_ff   <= above;
      // Flag cannot set before the input first rises
      armed_ff        <= armed_ff | above;
      input_undervoltage_flag_ff      <= nxt_input_undervoltage_flag;
      refresh_pend_ff <= st.uv_clear | (refresh_pend_ff & ~tick);
      tick_cnt_ff     <= tick ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      first_good_ff  <= 1'b0;
      second_good_ff <= 1'b0;
    end
    else
    begin
      first_good_ff  <= nxt_first_good;
      second_good_ff <= nxt_second_good;
    end
  end

  assign first_routed_good_pin  = first_good_ff;
  assign second_routed_good_pin = second_good_ff;
  assign st.live_status = {sync2_ff[SW-1], input_undervoltage_flag_ff, sync2_ff[NUM_OUTPUTS], pg};
endmodule // ssf_status_core
`default_nettype wire

/* verification/ssf_top_chk.sv */
// Port checks for the supply status flag block
`timescale 1ns/1ps
`default_nettype none
module ssf_top_chk
  import ssf_pkg::*;
#(
  parameter int NUM_OUTPUTS = SSF_NUM_OUTPUTS
)
(
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire logic                   scl_in,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire logic                   temp_warn_cmp,
  input wire logic                   input_above_uv_cmp,
  input wire logic                   main_supply_sense_pin,
  input wire logic [NUM_OUTPUTS-1:0] output_power_good_cmp,
  input wire logic [NUM_OUTPUTS-1:0] first_route_sel,
  input wire logic [NUM_OUTPUTS-1:0] second_route_sel,
  input wire logic                   first_routed_good_pin,
  input wire logic                   second_routed_good_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Sync plus register needs three edges
  sequence s_settled;
    ($stable(output_power_good_cmp) && $stable(first_route_sel)
      && $stable(second_route_sel))[*4];
  endsequence
  a_route_first_and: assert property (
    s_settled |-> first_routed_good_pin == &(output_power_good_cmp | ~first_route_sel))
    else $error("first routed pin not the AND of its selection");
  a_route_second_and: assert property (
    s_settled |-> second_routed_good_pin == &(output_power_good_cmp | ~second_route_sel))
    else $error("second routed pin not the AND of its selection");
  a_route_first_fall: assert property (
    $fell(output_power_good_cmp[0]) && first_route_sel[0] |-> ##[1:4] !first_routed_good_pin)
    else $error("first routed pin missed a falling good bit");
  a_route_second_fall: assert property (
    $fell(output_power_good_cmp[1]) && second_route_sel[1] |-> ##[1:4] !second_routed_good_pin)
    else $error("second routed pin missed a falling good bit");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed outside the clock low phase");
  a_oe_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  a_oe_reset_quiet: assert property ($rose(nrst) |-> (!sda_oe)[*3])
    else $error("data line driven right after reset");
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule // ssf_top_chk
bind ssf_top ssf_top_chk #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .temp_warn_cmp(temp_warn_cmp), .input_above_uv_cmp(input_above_uv_cmp),
  .main_supply_sense_pin(main_supply_sense_pin), .output_power_good_cmp(output_power_good_cmp),
  .first_route_sel(first_route_sel), .second_route_sel(second_route_sel),
  .first_routed_good_pin(first_routed_good_pin), .second_routed_good_pin(second_routed_good_pin));
`default_nettype wire

/* verification/ssf_host_model.sv */
// Management bus host model
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model
#(
  parameter logic [6:0] ADDR = 7'h2C
)
(
  input  wire logic sys_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic host_low = 1'b0;
  // Pull-up: a released line reads high
  assign sda = !(host_low || sda_oe);
  initial scl = 1'b1;
  task automatic half();
    repeat (8) @(posedge sys_clk);
  endtask
  // Data moves mid low phase, never beside a clock edge
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge sys_clk);
    host_low <= !b;
    repeat (5) @(posedge sys_clk);
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
                      output logic ack_n);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(nine, ack_n);
  endtask
  task automatic start();
    half();
    host_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    host_low <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    half();
    host_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    host_low <= 1'b0;
    half();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, v, output logic nak);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    xfer({a, 1'b0}, 1'b1, q, k0);
    xfer(p, 1'b1, q, k1);
    xfer(v, 1'b1, q, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, v, k);
    xfer(p, 1'b1, v, k);
    start();
    xfer({ADDR, 1'b1}, 1'b1, v, k);
    xfer(8'hFF, 1'b1, v, k);
    stop();
  endtask
  task automatic rd2(input logic [7:0] p, output logic [7:0] v0, v1);
    logic k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, v0, k);
    xfer(p, 1'b1, v0, k);
    start();
    xfer({ADDR, 1'b1}, 1'b1, v0, k);
    // Host acknowledges the first byte so the pointer advances
    xfer(8'hFF, 1'b0, v0, k);
    xfer(8'hFF, 1'b1, v1, k);
    stop();
  endtask
  task automatic wr2(input logic [7:0] p, v0, v1, output logic nak);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, k0);
    xfer(p, 1'b1, q, k1);
    xfer(v0, 1'b1, q, k2);
    xfer(v1, 1'b1, q, k3);
    stop();
    nak = k0 | k1 | k2 | k3;
  endtask
endmodule // ssf_host_model
`default_nettype wire

/* verification/ssf_top_tb.sv */
// Self-checking bench for the supply status flag block
`timescale 1ns/1ps
`default_nettype none
module ssf_top_tb
  import ssf_pkg::*;
;
  logic       sys_clk   = 1'b0;
  logic       nrst      = 1'b0;
  logic       temp      = 1'b0;
  logic       above     = 1'b0;
  logic       sense     = 1'b0;
  logic [4:0] good      = 5'h00;
  logic [4:0] sel1      = 5'h00;
  logic [4:0] sel2      = 5'h00;
  logic       scl, sda, sda_out, sda_oe, route1, route2, nak;
  logic [7:0] d;
  logic [7:0] d2;
  int         err_count = 0;
  int         n_checks  = 0;
  int         cyc       = 0;
  always #12.5 sys_clk = !sys_clk;
  ssf_top #(.REFRESH_CYCLES(16)) dut (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .temp_warn_cmp(temp),
    .input_above_uv_cmp(above), .main_supply_sense_pin(sense), .output_power_good_cmp(good),
    .first_route_sel(sel1), .second_route_sel(sel2), .first_routed_good_pin(route1),
    .second_routed_good_pin(route2));
  ssf_host_model #(.ADDR(SSF_DEV_ADDR_DFLT)) host (.sys_clk(sys_clk), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic drive(input logic t, a, s, input logic [4:0] g);
    @(posedge sys_clk);
    temp  <= t;
    above <= a;
    sense <= s;
    good  <= g;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic t_live();
    drive(1'b1, 1'b0, 1'b1, 5'h15);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'hB5, d);
    drive(1'b0, 1'b0, 1'b0, 5'h0A);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h0A, d);
  endtask
  task automatic t_sticky();
    drive(1'b0, 1'b1, 1'b1, 5'h1F);
    drive(1'b0, 1'b0, 1'b1, 5'h1F);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h7F, d);
    drive(1'b0, 1'b1, 1'b0, 5'h1F);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h5F, d);
    host.wr(SSF_DEV_ADDR_DFLT, SSF_STATUS_OFFSET, 8'hBF, nak);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h5F, d);
    host.wr(SSF_DEV_ADDR_DFLT, SSF_STATUS_OFFSET, 8'hFF, nak);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h1F, d);
  endtask
  task automatic t_refresh();
    drive(1'b0, 1'b0, 1'b0, 5'h1F);
    host.wr(SSF_DEV_ADDR_DFLT, SSF_STATUS_OFFSET, 8'h40, nak);
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h5F, d);
  endtask
  task automatic t_other();
    // Input back above threshold so a refresh cannot hide a wrong clear
    drive(1'b0, 1'b1, 1'b0, 5'h1F);
    host.rd(8'h1B, d);
    chk("unmapped", 8'h00, d);
    host.wr(SSF_DEV_ADDR_DFLT, 8'h1B, 8'hFF, nak);
    chk("write ack", 8'h00, {7'h00, nak});
    host.wr(SSF_DEV_ADDR_DFLT ^ 7'h01, SSF_STATUS_OFFSET, 8'h40, nak);
    chk("foreign ack", 8'h01, {7'h00, nak});
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h5F, d);
    host.rd2(SSF_STATUS_OFFSET - 8'h01, d, d2);
    chk("burst first", 8'h00, d);
    chk("burst second", 8'h5F, d2);
    host.wr2(SSF_STATUS_OFFSET - 8'h01, 8'hFF, 8'h40, nak);
    chk("burst ack", 8'h00, {7'h00, nak});
    host.rd(SSF_STATUS_OFFSET, d);
    chk("status", 8'h1F, d);
  endtask
  task automatic t_route();
    @(posedge sys_clk);
    sel1 <= 5'h05;
    sel2 <= 5'h0A;
    drive(1'b0, 1'b0, 1'b0, 5'h1F);
    chk("routed", 8'h03, {6'h00, route1, route2});
    drive(1'b0, 1'b0, 1'b0, 5'h1E);
    chk("routed", 8'h01, {6'h00, route1, route2});
    drive(1'b0, 1'b0, 1'b0, 5'h1D);
    chk("routed", 8'h02, {6'h00, route1, route2});
    @(posedge sys_clk);
    sel1 <= 5'h00;
    sel2 <= 5'h00;
    repeat (5) @(posedge sys_clk);
    chk("routed", 8'h03, {6'h00, route1, route2});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // About 11000 cycles of traffic expected
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_live();
    t_sticky();
    t_refresh();
    t_other();
    t_route();
    test_done();
  end
endmodule // ssf_top_tb
`default_nettype wire
